//--- uet_defines.svh
/*
  Constants of the endpoint transaction engine: FIFO sizes, transfer type
  codes and handshake codes. Assumes inclusion by bare name.
*/
`ifndef UET_DEFINES_SVH
`define UET_DEFINES_SVH

// ----------------------------------------
// FIFO geometry
// ----------------------------------------
`define UET_DEPTH 7'h40
`define UET_PTR_W 7
`define UET_CNT_W 10

// ----------------------------------------
// Transfer type field and handshakes
// ----------------------------------------
`define UET_TYPE_CTRL 2'h0
`define UET_TYPE_ISO 2'h1
`define UET_TYPE_BULK 2'h2
`define UET_TYPE_INTR 2'h3
`define UET_HS_ACK 2'h1
`define UET_HS_NAK 2'h2

`endif

//--- uet_engine.sv
/*
  Endpoint transaction engine: ping-pong bulk/interrupt IN, control stages,
  isochronous OUT and IN. Assumes a serial interface engine that decodes
  tokens, delivers OUT bytes with an end pulse and CRC verdict, reports the
  host ACK after IN data, and drains the transmit stream. Firmware drives
  the one-cycle flag strobes and the FIFO port.
*/
// What this block does
// - Ping-pong IN: ready bank sent at next IN, firmware fills other bank
// - Bulk/interrupt IN: done flag only after host acknowledges the packet
// - Firmware clears done before refilling; banks then switch automatically
// - Ping-pong IN: firmware bank toggles at each ready strobe
// - Bulk/interrupt IN: NAK every IN until that bank is ready
// - Setup packet sets setup flag, clears other status bits, may interrupt
// - Control endpoint serves both directions; others serve one direction
// - OUT data stage: bank-0 flag per valid packet; clear resets FIFO
// - Isochronous OUT sets receive flag on any packet; empty counts zero
// - Isochronous OUT: CRC error bit updated on every packet taken into an empty bank
// - Isochronous OUT never NAKs; data into a full bank is dropped
// - Isochronous OUT: clear during a packet stores the bytes from its own cycle on
// - Excess bytes dropped; packet still valid when CRC is good
// - Ping-pong OUT: clearing the read bank's flag switches the read bank
// - Ping-pong OUT: bank flags set alternately, one per packet
// - Isochronous IN without ready sends nothing, not even a handshake
// - Isochronous IN: done flag set once sent, without waiting for ACK
// - Transfer type: control, isochronous, bulk, interrupt as 0 to 3
// - FIFO reset clears pointers, byte counts and the data toggle
// - Non-isochronous OUT is NAKed while target bank is full
`default_nettype none
`include "uet_defines.svh"

module uet_engine
  import uet_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Endpoint configuration
  input wire logic [1:0] endpointTransferType,
  input wire logic pingPongEn,
  input wire logic epDirIn,
  input wire logic ctrlDirIn,
  input wire logic endpointFifoReset,
  // Firmware flag strobes
  input wire logic fwSetTxReady,
  input wire logic fwClrTxDone,
  input wire logic fwClrRxBank0,
  input wire logic fwClrRxBank1,
  input wire logic fwClrSetup,
  input wire logic fwClrStallCrc,
  // Firmware FIFO port
  input wire logic fwWrValid,
  input wire logic [7:0] fwWrData,
  input wire logic fwRdReq,
  output logic [7:0] fwRdData,
  output logic [`UET_CNT_W-1:0] endpointByteCount,
  // Status and interrupt
  output uetStatus_t endpointStatusReg,
  input wire uetStatus_t intEnable,
  output logic usbIrq,
  output logic dataToggleBit,
  // Serial engine: tokens and receive stream
  input wire logic tokIn,
  input wire logic tokOut,
  input wire logic tokSetup,
  input wire uetRxIn_t rxIn,
  input wire logic hostAck,
  // Serial engine: handshake and transmit stream
  output logic hsValid,
  output logic [1:0] hsCode,
  output logic txValid,
  input wire logic txReady,
  output uetBeat_t txBeat
);

  // ----------------------------------------
  // State and storage
  // ----------------------------------------
  uetCore_t s_r;
  uetCore_t s_nxt;
  logic [7:0] fifoMem [2][`UET_DEPTH];
  logic memWe;
  logic memBank;
  logic [5:0] memAddr;
  logic [7:0] memData;
  logic bufInValid;
  logic bufInReady;
  uetBeat_t bufInBeat;
  logic isIso;
  logic isCtrl;
  logic pp;

  assign isIso = (endpointTransferType == `UET_TYPE_ISO);
  assign isCtrl = (endpointTransferType == `UET_TYPE_CTRL);
  // Control endpoints never run banked
  assign pp = pingPongEn && !isCtrl;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic uetCore_t clrBank(uetCore_t c, logic b);
    c.wrPtr[b] = '0;
    c.rdPtr[b] = '0;
    c.cnt[b] = '0;
    return c;
  endfunction

  function automatic uetCore_t finishTx(uetCore_t c, logic bank);
    c = clrBank(c, c.txBank);
    c.txDone = 1'b1;
    c.tx_packet_ready[c.txBank] = 1'b0;
    c.toggle = ~c.toggle;
    if (bank) c.txBank = ~c.txBank;
    c.state = ST_IDLE;
    return c;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [`UET_PTR_W-1:0] len;
    logic [`UET_PTR_W-1:0] idx;
    logic b;
    s_nxt = s_r;
    s_nxt.hsValid = 1'b0;
    memWe = 1'b0;
    memBank = 1'b0;
    memAddr = '0;
    memData = '0;
    len = s_r.wrPtr[s_r.txBank];
    idx = s_r.rdPtr[s_r.txBank];
    b = s_r.rxBank;
    bufInValid = (s_r.state == ST_SEND);
    bufInBeat.data = fifoMem[s_r.txBank][idx[5:0]];
    bufInBeat.empty = (len == '0);
    bufInBeat.last = (len == '0) || (idx + 7'h1 == len);

    // Firmware clears come first so that a same-cycle hardware set wins
    if (fwClrTxDone) s_nxt.txDone = 1'b0;
    if (fwClrStallCrc) s_nxt.stallCrc = 1'b0;
    if (fwClrSetup) begin
      s_nxt.setup = 1'b0;
      s_nxt = clrBank(s_nxt, 1'b0);
    end
    if (fwClrRxBank0) begin
      s_nxt.rxFull[0] = 1'b0;
      s_nxt = clrBank(s_nxt, 1'b0);
      if (pp && !s_r.rdBank) s_nxt.rdBank = 1'b1;
    end
    if (fwClrRxBank1) begin
      s_nxt.rxFull[1] = 1'b0;
      s_nxt = clrBank(s_nxt, 1'b1);
      if (pp && s_r.rdBank) s_nxt.rdBank = 1'b0;
    end

    // Firmware loads the bank it owns; readiness hands that bank over
    if (fwWrValid && s_r.wrPtr[s_r.fwBank] < `UET_DEPTH) begin
      memWe = 1'b1;
      memBank = s_r.fwBank;
      memAddr = s_r.wrPtr[s_r.fwBank][5:0];
      memData = fwWrData;
      s_nxt.wrPtr[s_r.fwBank] = s_r.wrPtr[s_r.fwBank] + 7'h1;
    end
    if (fwSetTxReady) begin
      s_nxt.tx_packet_ready[s_r.fwBank] = 1'b1;
      if (pp) s_nxt.fwBank = ~s_r.fwBank;
    end
    if (fwRdReq) begin
      s_nxt.fwRdData = fifoMem[s_r.rdBank][s_r.rdPtr[s_r.rdBank][5:0]];
      s_nxt.rdPtr[s_r.rdBank] = s_r.rdPtr[s_r.rdBank] + 7'h1;
    end

    case (s_r.state)
      ST_IDLE: begin
        // Control takes both token kinds; others only their own direction
        if (tokIn && (isCtrl || epDirIn)) begin
          if (s_r.tx_packet_ready[s_r.txBank]) begin
            s_nxt.rdPtr[s_r.txBank] = '0;
            s_nxt.state = ST_SEND;
          end else if (!isIso) begin
            s_nxt.hsValid = 1'b1;
            s_nxt.hsCode = `UET_HS_NAK;
          end
          // Isochronous with nothing ready stays silent
        end else if ((tokOut && (isCtrl || !epDirIn)) || (tokSetup && isCtrl)) begin
          s_nxt.setup_received_flag = tokSetup;
          // Setup always lands in bank 0, overriding a held packet
          s_nxt.rxDrop = !tokSetup && !isIso && s_r.rxFull[b];
          if (tokSetup) begin
            s_nxt.rxBank = 1'b0;
            s_nxt = clrBank(s_nxt, 1'b0);
          end else if (!s_r.rxFull[b]) begin
            s_nxt = clrBank(s_nxt, b);
          end
          s_nxt.state = ST_RECV;
        end
      end
      ST_RECV: begin
        if (rxIn.valid && !s_r.rxDrop && (s_r.setup_received_flag || !s_nxt.rxFull[b])) begin
          // Full-bank check per byte: bytes after a mid-packet clear land
          // Next-state pointer: a clear in this very cycle rewinds the bank first
          if (s_nxt.wrPtr[b] < `UET_DEPTH) begin
            memWe = 1'b1;
            memBank = b;
            memAddr = s_nxt.wrPtr[b][5:0];
            memData = rxIn.data;
            s_nxt.wrPtr[b] = s_nxt.wrPtr[b] + 7'h1;
          end
          s_nxt.cnt[b] = s_nxt.cnt[b] + 10'h001;
        end
        if (rxIn.endPkt) begin
          s_nxt.state = ST_IDLE;
          if (s_r.setup_received_flag) begin
            if (rxIn.crcOk) begin
              s_nxt.setup = 1'b1;
              s_nxt.tx_packet_ready = 2'b00;
              s_nxt.txDone = 1'b0;
              s_nxt.rxFull = 2'b00;
              s_nxt.stallCrc = 1'b0;
              s_nxt.toggle = 1'b1;
              s_nxt.hsValid = 1'b1;
              s_nxt.hsCode = `UET_HS_ACK;
            end else begin
              s_nxt = clrBank(s_nxt, 1'b0);
            end
          end else if (isIso) begin
            if (!s_nxt.rxFull[b]) begin
              // Any packet counts; an empty one leaves the count at zero
              s_nxt.rxFull[b] = 1'b1;
              s_nxt.stallCrc = !rxIn.crcOk;
              if (pp) s_nxt.rxBank = ~b;
            end
          end else if (s_r.rxDrop) begin
            s_nxt.hsValid = 1'b1;
            s_nxt.hsCode = `UET_HS_NAK;
          end else if (rxIn.crcOk) begin
            s_nxt.rxFull[b] = 1'b1;
            s_nxt.toggle = ~s_r.toggle;
            if (pp) s_nxt.rxBank = ~b;
            s_nxt.hsValid = 1'b1;
            s_nxt.hsCode = `UET_HS_ACK;
          end else begin
            // Bad CRC: host retries, the bank is simply rewound
            s_nxt = clrBank(s_nxt, b);
          end
        end
      end
      ST_SEND: begin
        if (bufInReady && bufInBeat.last) begin
          if (isIso) s_nxt = finishTx(s_nxt, pp);
          else s_nxt.state = ST_WACK;
        end else if (bufInReady) begin
          s_nxt.rdPtr[s_r.txBank] = idx + 7'h1;
        end
      end
      ST_WACK: begin
        if (hostAck) begin
          s_nxt = finishTx(s_nxt, pp);
        end else if (tokIn) begin
          // No ACK came: the host retries and the bank is resent whole
          s_nxt.rdPtr[s_r.txBank] = '0;
          s_nxt.state = ST_SEND;
        end else if (tokOut || tokSetup) begin
          s_nxt.state = ST_IDLE;
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase

    // Bank number survives a FIFO reset on purpose
    if (endpointFifoReset) begin
      s_nxt = clrBank(s_nxt, 1'b0);
      s_nxt = clrBank(s_nxt, 1'b1);
      s_nxt.toggle = 1'b0;
    end
    s_nxt.cntOut = s_nxt.cnt[s_nxt.rdBank];
  end

  // ----------------------------------------
  // Registers and FIFO memory
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // No reset: contents are only read behind valid pointers
  always_ff @(posedge clk) begin
    if (memWe) fifoMem[memBank][memAddr] <= memData;
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  uet_skid_buf txBuf (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inBeat(bufInBeat),
    .outValid(txValid),
    .outReady(txReady),
    .outBeat(txBeat)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    endpointStatusReg.txPacketReady = s_r.tx_packet_ready[s_r.fwBank] | s_r.tx_packet_ready[s_r.txBank];
    endpointStatusReg.txDoneFlag = s_r.txDone;
    endpointStatusReg.rxBank0Full = s_r.rxFull[0];
    endpointStatusReg.rxBank1Full = s_r.rxFull[1];
    endpointStatusReg.setupReceivedFlag = s_r.setup;
    endpointStatusReg.stallOrCrcErrorFlag = s_r.stallCrc;
  end

  assign usbIrq = |(endpointStatusReg & intEnable);
  assign fwRdData = s_r.fwRdData;
  assign endpointByteCount = s_r.cntOut;
  assign dataToggleBit = s_r.toggle;
  assign hsValid = s_r.hsValid;
  assign hsCode = s_r.hsCode;

endmodule

`default_nettype wire

//--- uet_engine_asserts.sv
/*
  Concurrent checks on the ports of uet_engine, bound to every instance.
  Assumes the transfer type only changes while the engine is idle.
*/
`default_nettype none
`include "uet_defines.svh"

module uet_engine_asserts
  import uet_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs watched
  input wire logic [1:0] endpointTransferType,
  input wire logic pingPongEn,
  input wire logic endpointFifoReset,
  input wire logic tokIn,
  input wire uetRxIn_t rxIn,
  input wire logic hostAck,
  input wire uetStatus_t intEnable,
  // Outputs watched
  input wire logic hsValid,
  input wire logic [1:0] hsCode,
  input wire logic txValid,
  input wire uetStatus_t endpointStatusReg,
  input wire logic usbIrq,
  input wire logic [`UET_CNT_W-1:0] endpointByteCount,
  input wire logic dataToggleBit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire uetStatus_t st = endpointStatusReg;
  wire logic iso = endpointTransferType == `UET_TYPE_ISO;

  property p_irq; usbIrq == |(st & intEnable); endproperty
  a_irq: assert property (p_irq) else $error("irq differs from flags");
  property p_nakIn; tokIn && !iso && !st.txPacketReady && !txValid
    |=> hsValid && hsCode == `UET_HS_NAK; endproperty
  a_nakIn: assert property (p_nakIn) else $error("IN not refused");
  property p_isoQuiet; tokIn && iso && !st.txPacketReady |=> (!hsValid && !txValid)[*4];
  endproperty
  a_isoQuiet: assert property (p_isoQuiet) else $error("iso IN answered");
  // Allow one or two cycles from the host's acknowledge to the flag
  property p_ack; $rose(st.txDoneFlag) && !iso |-> $past(hostAck) || $past(hostAck, 2);
  endproperty
  a_ack: assert property (p_ack) else $error("done without ack");
  property p_setup; $rose(st.setupReceivedFlag) |-> st == 6'h02 && dataToggleBit;
  endproperty
  a_setup: assert property (p_setup) else $error("setup flags wrong");
  property p_isoNoHs; hsValid |-> $past(endpointTransferType) != `UET_TYPE_ISO; endproperty
  a_isoNoHs: assert property (p_isoNoHs) else $error("iso handshake");
  property p_fifoRst; endpointFifoReset |=> endpointByteCount == 0 && !dataToggleBit;
  endproperty
  a_fifoRst: assert property (p_fifoRst) else $error("fifo reset");
  property p_outNak; rxIn.endPkt && rxIn.crcOk && endpointTransferType == `UET_TYPE_BULK
    && !pingPongEn && st.rxBank0Full |=> hsValid && hsCode == `UET_HS_NAK; endproperty
  a_outNak: assert property (p_outNak) else $error("OUT not refused");

  c_setup: cover property ($rose(st.setupReceivedFlag));
  c_done: cover property ($rose(st.txDoneFlag));
  c_bank1: cover property ($rose(st.rxBank1Full));
endmodule

bind uet_engine uet_engine_asserts chk (.clk, .rst_n, .endpointTransferType, .pingPongEn,
  .endpointFifoReset, .tokIn, .rxIn, .hostAck, .intEnable, .hsValid, .hsCode, .txValid,
  .endpointStatusReg, .usbIrq, .endpointByteCount, .dataToggleBit);

`default_nettype wire

//--- uet_host_model.sv
/*
  Host and serial-engine model: tokens, OUT data, acknowledges, drains IN.
  Assumes the bench calls one task at a time.
*/
`default_nettype none

module uet_host_model
  import uet_pkg::*;
(
  // Clock
  input wire logic clk,
  // Toward the engine
  output logic tokIn,
  output logic tokOut,
  output logic tokSetup,
  output uetRxIn_t rxIn,
  output logic hostAck,
  output logic txReady,
  // From the engine
  input wire logic hsValid,
  input wire logic [1:0] hsCode,
  input wire logic txValid,
  input wire uetBeat_t txBeat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall = 1'b0;
  int hsN = 0;
  logic [1:0] hsLast = 2'h0;
  uetBeat_t got[$];

  initial begin
    {tokIn, tokOut, tokSetup, hostAck, txReady} = 5'h01;
    rxIn = '0;
  end
  // A stalling host is ready only every other cycle
  always @(posedge clk) begin
    if (hsValid) begin
      hsN++;
      hsLast = hsCode;
    end
    if (txValid && txReady)
      got.push_back(txBeat);
    #1 txReady = !stall || !txReady;
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic inTok;
    tokIn = 1'b1;
    tick();
    tokIn = 1'b0;
  endtask
  task automatic ack;
    hostAck = 1'b1;
    tick();
    hostAck = 1'b0;
  endtask
  // Idle data is inverted so a stale byte is never mistaken for a stored one
  task automatic outPkt(input logic setup, input int n, input logic good, input logic [7:0] b);
    tokSetup = setup;
    tokOut = !setup;
    tick();
    {tokSetup, tokOut} = 2'h0;
    for (int i = 0; i < n; i++) begin
      rxIn = '{1'b1, b + 8'(i), 1'b0, 1'b0};
      tick();
    end
    rxIn = '{1'b0, ~rxIn.data, 1'b1, good};
    tick();
    rxIn = '{1'b0, ~rxIn.data, 1'b0, 1'b0};
  endtask
endmodule

`default_nettype wire

//--- uet_pkg.sv
/*
  Types shared by the endpoint transaction engine and its transmit buffer.
  Assumes uet_defines.svh is on the include path.
*/
`default_nettype none
`include "uet_defines.svh"

package uet_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RECV = 4'h2,
    ST_SEND = 4'h4,
    ST_WACK = 4'h8
  } uetState_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic empty;
  } uetBeat_t;

  typedef struct packed {
    logic txPacketReady;
    logic txDoneFlag;
    logic rxBank0Full;
    logic rxBank1Full;
    logic setupReceivedFlag;
    logic stallOrCrcErrorFlag;
  } uetStatus_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic endPkt;
    logic crcOk;
  } uetRxIn_t;

  typedef struct packed {
    uetBeat_t b0;
    uetBeat_t b1;
    logic [1:0] count;
  } uetBuf_t;

  typedef struct packed {
    uetState_t state;
    logic [1:0] tx_packet_ready;
    logic fwBank;
    logic txBank;
    logic rxBank;
    logic rdBank;
    logic txDone;
    logic [1:0] rxFull;
    logic setup;
    logic stallCrc;
    logic toggle;
    logic [1:0][`UET_PTR_W-1:0] wrPtr;
    logic [1:0][`UET_PTR_W-1:0] rdPtr;
    logic [1:0][`UET_CNT_W-1:0] cnt;
    logic setup_received_flag;
    logic rxDrop;
    logic hsValid;
    logic [1:0] hsCode;
    logic [7:0] fwRdData;
    logic [`UET_CNT_W-1:0] cntOut;
  } uetCore_t;

endpackage

`default_nettype wire

//--- uet_skid_buf.sv
/*
  Two-entry buffer between the engine and the serial transmitter.
  Assumes one clock; the drain side may stall at any time.
*/
`default_nettype none

module uet_skid_buf
  import uet_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire uetBeat_t inBeat,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output uetBeat_t outBeat
);

  uetBuf_t s_r;
  uetBuf_t s_nxt;
  logic push;
  logic pop;

  assign inReady = (s_r.count != 2'h2);
  assign outValid = (s_r.count != 2'h0);
  assign outBeat = s_r.b0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    s_nxt = s_r;
    case ({push, pop})
      2'b10: begin
        if (s_r.count == 2'h0) s_nxt.b0 = inBeat;
        else s_nxt.b1 = inBeat;
        s_nxt.count = s_r.count + 2'h1;
      end
      2'b01: begin
        s_nxt.b0 = s_r.b1;
        s_nxt.count = s_r.count - 2'h1;
      end
      2'b11: begin
        // Count is one here: the sole entry leaves as the new one lands
        s_nxt.b0 = inBeat;
      end
      default: s_nxt = s_r;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_r <= '0;
    else s_r <= s_nxt;
  end

endmodule

`default_nettype wire

//--- usb_endpoint_transaction_engine_bench.sv
/*
  Self-checking bench of uet_engine with the host model on its serial side.
  Assumes strobes show in the status one cycle after they are taken.
*/
`default_nettype none
`include "uet_defines.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("MISMATCH %0t got=%h exp=%h", $time, a, b); end end

module usb_endpoint_transaction_engine_bench
  import uet_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, pp = 1'b1, dirIn = 1'b1, ctrlDir = 1'b0, fifoRst = 1'b0;
  logic [1:0] endpoint_transfer_type = `UET_TYPE_BULK;
  logic [5:0] stb = 6'h00;
  logic wrV = 1'b0, rdReq = 1'b0;
  logic [7:0] wrD = 8'h00;
  uetStatus_t intEn = 6'h10;
  wire logic [7:0] rdData;
  wire logic [`UET_CNT_W-1:0] byteCnt;
  wire uetStatus_t st;
  wire logic irq, tgl, tokIn, tokOut, tokSetup, hostAck, hsValid, txValid, txReady;
  wire logic [1:0] hsCode;
  wire uetRxIn_t rxIn;
  wire uetBeat_t txBeat;
  int err_count = 0, tests_run = 0;

  always #20 clk = ~clk;

  uet_engine dut (.clk, .rst_n, .endpointTransferType(endpoint_transfer_type), .pingPongEn(pp),
    .epDirIn(dirIn), .ctrlDirIn(ctrlDir), .endpointFifoReset(fifoRst),
    .fwSetTxReady(stb[0]), .fwClrTxDone(stb[1]), .fwClrRxBank0(stb[2]),
    .fwClrRxBank1(stb[3]), .fwClrSetup(stb[4]), .fwClrStallCrc(stb[5]),
    .fwWrValid(wrV), .fwWrData(wrD), .fwRdReq(rdReq), .fwRdData(rdData),
    .endpointByteCount(byteCnt), .endpointStatusReg(st), .intEnable(intEn),
    .usbIrq(irq), .dataToggleBit(tgl), .tokIn, .tokOut, .tokSetup, .rxIn,
    .hostAck, .hsValid, .hsCode, .txValid, .txReady, .txBeat);
  uet_host_model host (.clk, .tokIn, .tokOut, .tokSetup, .rxIn, .hostAck,
    .txReady, .hsValid, .hsCode, .txValid, .txBeat);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic strobe(input int b);
    stb[b] = 1'b1;
    tick();
    stb[b] = 1'b0;
  endtask
  task automatic fifoClear;
    fifoRst = 1'b1;
    tick();
    fifoRst = 1'b0;
    tick();
  endtask
  task automatic wr(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      wrV = 1'b1;
      wrD = b + 8'(i);
      tick();
    end
    wrV = 1'b0;
  endtask
  task automatic inPkt(input int n, input logic [7:0] b);
    int m;
    m = (n == 0) ? 1 : n;
    host.got.delete();
    host.inTok();
    for (int i = 0; i < 200 && host.got.size() < m; i++) tick();
    for (int i = 0; i < n; i++) `CHK(host.got[i].data, b + 8'(i))
    `CHK(host.got[m-1].last, 1'b1)
    `CHK(host.got[0].empty, n == 0)
  endtask
  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tBulkIn;
    int n0;
    n0 = host.hsN;
    `CHK(st, 6'h00)
    host.inTok();
    tick(3);
    `CHK(host.hsN, n0 + 1)
    `CHK(host.hsLast, `UET_HS_NAK)
    wr(3, 8'h30);
    strobe(0);
    tick();
    `CHK(st.txPacketReady, 1'b1)
    wr(2, 8'h40);
    host.stall = 1'b1;
    inPkt(3, 8'h30);
    tick(3);
    `CHK(st.txDoneFlag, 1'b0)
    host.ack();
    tick(2);
    `CHK(st.txDoneFlag, 1'b1)
    `CHK(irq, 1'b1)
    strobe(1);
    strobe(0);
    inPkt(2, 8'h40);
    host.ack();
    tick(2);
    strobe(1);
    host.stall = 1'b0;
    tick();
    `CHK(st, 6'h00)
    fin("bulk in");
  endtask
  task automatic tControl;
    endpoint_transfer_type = `UET_TYPE_CTRL;
    pp = 1'b0;
    fifoClear();
    host.outPkt(1'b0, 4, 1'b1, 8'h50);
    tick(2);
    `CHK(st.rxBank0Full, 1'b1)
    host.outPkt(1'b1, 8, 1'b1, 8'h60);
    tick(2);
    `CHK(st, 6'h02)
    `CHK(byteCnt, 10'h008)
    rdReq = 1'b1;
    tick();
    rdReq = 1'b0;
    tick();
    `CHK(rdData, 8'h60)
    strobe(4);
    strobe(0);
    inPkt(0, 8'h00);
    host.ack();
    tick(2);
    `CHK(st.txDoneFlag, 1'b1)
    strobe(1);
    fin("control");
  endtask
  task automatic tBulkOut;
    endpoint_transfer_type = `UET_TYPE_BULK;
    dirIn = 1'b0;
    host.outPkt(1'b0, 66, 1'b1, 8'h00);
    tick(2);
    `CHK(host.hsLast, `UET_HS_ACK)
    `CHK(byteCnt, 10'h042)
    host.outPkt(1'b0, 2, 1'b1, 8'h00);
    tick(2);
    `CHK(host.hsLast, `UET_HS_NAK)
    fifoClear();
    `CHK(byteCnt, 10'h000)
    `CHK(tgl, 1'b0)
    strobe(2);
    fin("bulk out");
  endtask
  task automatic tIsoOut;
    int n0;
    endpoint_transfer_type = `UET_TYPE_ISO;
    pp = 1'b1;
    n0 = host.hsN;
    host.outPkt(1'b0, 3, 1'b1, 8'h70);
    host.outPkt(1'b0, 5, 1'b0, 8'h80);
    tick(2);
    `CHK(st, 6'h0D)
    `CHK(byteCnt, 10'h003)
    host.outPkt(1'b0, 4, 1'b1, 8'h90);
    tick(2);
    `CHK(host.hsN, n0)
    `CHK(byteCnt, 10'h003)
    strobe(2);
    tick();
    `CHK(byteCnt, 10'h005)
    host.outPkt(1'b0, 0, 1'b1, 8'h00);
    tick(2);
    `CHK(st.stallOrCrcErrorFlag, 1'b0)
    `CHK(st.rxBank0Full, 1'b1)
    strobe(3);
    tick();
    `CHK(byteCnt, 10'h000)
    strobe(2);
    // Bank 1 is the target and full; the clear lands after two bytes are lost
    host.outPkt(1'b0, 2, 1'b1, 8'hB0);
    host.outPkt(1'b0, 2, 1'b1, 8'hC0);
    fork
      host.outPkt(1'b0, 4, 1'b1, 8'hD0);
      begin
        tick(3);
        strobe(3);
      end
    join
    strobe(2);
    tick();
    `CHK(byteCnt, 10'h002)
    rdReq = 1'b1;
    tick();
    rdReq = 1'b0;
    tick();
    `CHK(rdData, 8'hD2)
    fin("iso out");
  endtask
  task automatic tIsoIn;
    int n0;
    pp = 1'b0;
    dirIn = 1'b1;
    fifoClear();
    n0 = host.hsN;
    host.got.delete();
    host.inTok();
    tick(4);
    `CHK(host.hsN, n0)
    `CHK(host.got.size(), 0)
    wr(2, 8'hA0);
    strobe(0);
    inPkt(2, 8'hA0);
    tick(2);
    `CHK(st.txDoneFlag, 1'b1)
    fin("iso in");
  endtask

  initial begin
    tick(12);
    rst_n = 1'b1;
    tBulkIn();
    tControl();
    tBulkOut();
    tIsoOut();
    tIsoIn();
    summarize();
  end
  // The scenarios need a few hundred cycles; twenty thousand means a hang
  initial begin
    #800000;
    err_count++;
    summarize();
  end
endmodule

`default_nettype wire
